// file: exec_slice.sv
/*
 * Execution slice: page call, page jump, add, add with carry, and the
 * byte logical-AND forms. Owns accumulator, flags, stack pointer and
 * program counter. Assumes data RAM reads combinationally and that the
 * four port output latches are readable at latch_rdata by latch_sel.
 */
// Functional notes
// - Call adds two to counter, pushes low then high, stack up by two.
// - Call target is upper five counter bits, opcode 7-5, second byte.
// - Call decodes on low bits 10001; two bytes, three cycles.
// - Call leaves all status flags unchanged.
// - Jump adds two, replaces counter bits 10-0, stays within 2K block.
// - Both adds set carry from bit 7, aux carry from bit 3.
// - Overflow is carry out of bit 6 xor carry out of bit 7.
// - Add with carry sums accumulator, source and carry flag.
// - Plain add supports register, direct, indirect, immediate sources.
// - Add with carry supports the same four source modes.
// - Byte AND stores bitwise result in destination, flags untouched.
// - AND on an output port reads and rewrites the port latch.
// - Six AND combinations, accumulator or direct destination; direct with immediate is refused here.
// - AND register, indirect and direct-with-accumulator encodings.
`timescale 1ns/1ps
`default_nettype none
module exec_slice
    import exec_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        issue_valid,
    output logic             issue_ready,
    input  wire instr_t      issue,
    input  wire logic [1:0]  bank_sel,
    output mem_req_t         mem_req,
    input  wire logic [7:0]  mem_rdata,
    output logic      [1:0]  latch_sel,
    input  wire logic [7:0]  latch_rdata,
    output logic             latch_we,
    output logic      [7:0]  latch_wdata,
    output logic      [7:0]  acc,
    output flags_t           flags,
    output logic      [7:0]  stack_pointer,
    output logic     [15:0]  program_counter,
    output logic             done,
    output logic             unsupported
);
    typedef struct packed {
        exec_st_t    st;
        instr_t      ins;
        op_cls_t     cls;
        src_mode_t   src;
        logic [7:0]  ptr;
        logic [7:0]  acc;
        flags_t      fl;
        logic [7:0]  sp;
        logic [15:0] pc;
        logic        done;
        logic        bad;
    } state_t;

    localparam state_t STATE_RESET = '{st: ST_IDLE, ins: '0, cls: CLS_NONE,
        src: SRC_REG, ptr: 8'h00, acc: 8'h00, fl: '0, sp: SP_RESET,
        pc: PC_RESET, done: 1'b0, bad: 1'b0};

    state_t      s_r;
    state_t      s_nxt;
    op_cls_t     dec_cls;
    src_mode_t   dec_src;
    logic [7:0]  src_byte;
    logic [7:0]  dir_addr;
    logic        dir_is_port;
    logic [7:0]  add_sum;
    flags_t      add_fl;
    logic        add_cin;
    logic [15:0] pc_inc;
    logic [15:0] page_tgt;

    // Opcode classification
    always_comb begin
        dec_cls = CLS_NONE;
        dec_src = SRC_REG;
        if (issue.opcode[4:0] == CALL_LOW5) begin
            dec_cls = CLS_CALL;
        end else if (issue.opcode[4:0] == JMP_LOW5) begin
            dec_cls = CLS_JMP;
        end else if (issue.opcode == AND_DIR_ACC) begin
            dec_cls = CLS_ANDD;
            dec_src = SRC_DIR;
        end else if (issue.opcode[7:4] == ADD_HI ||
                     issue.opcode[7:4] == ADD_WITH_CARRY_HI ||
                     issue.opcode[7:4] == AND_HI) begin
            if (issue.opcode[3]) begin
                dec_src = SRC_REG;
            end else if (issue.opcode[3:1] == LO_IND3) begin
                dec_src = SRC_IND;
            end else if (issue.opcode[3:0] == LO_DIR) begin
                dec_src = SRC_DIR;
            end else begin
                dec_src = SRC_IMM;
            end
            if (!issue.opcode[3] && issue.opcode[3:1] != LO_IND3 &&
                issue.opcode[3:0] != LO_DIR && issue.opcode[3:0] != LO_IMM) begin
                dec_cls = CLS_NONE;
            end else if (issue.opcode[7:4] == ADD_HI) begin
                dec_cls = CLS_ADD;
            end else if (issue.opcode[7:4] == ADD_WITH_CARRY_HI) begin
                dec_cls = CLS_ADD_WITH_CARRY;
            end else begin
                dec_cls = CLS_AND;
            end
        end
    end

    assign pc_inc   = s_r.pc + PC_STEP2;
    assign page_tgt = {pc_inc[15:11], s_r.ins.opcode[7:5], s_r.ins.operand};
    assign dir_addr = s_r.ins.operand;
    assign dir_is_port = dir_addr[7] && (dir_addr[3:0] == PORT_LOW);
    assign latch_sel   = dir_addr[5:4];

    // Source operand: any direct operand at a port address reads the latch, not the pins
    always_comb begin
        case (s_r.src)
            SRC_IMM: src_byte = s_r.ins.operand;
            SRC_DIR: src_byte = dir_is_port ? latch_rdata : mem_rdata;
            default: src_byte = mem_rdata;
        endcase
    end

    assign add_cin = (s_r.cls == CLS_ADD_WITH_CARRY) ? s_r.fl.cy : 1'b0;

    byte_adder u_add (
        .a     (s_r.acc),
        .b     (src_byte),
        .cin   (add_cin),
        .sum   (add_sum),
        .flags (add_fl)
    );

    always_comb begin
        s_nxt         = s_r;
        s_nxt.done    = 1'b0;
        s_nxt.bad     = 1'b0;
        mem_req       = '0;
        latch_we      = 1'b0;
        latch_wdata   = 8'h00;
        case (s_r.st)
            ST_IDLE: begin
                if (issue_valid) begin
                    s_nxt.ins = issue;
                    s_nxt.cls = dec_cls;
                    s_nxt.src = dec_src;
                    if (dec_cls == CLS_NONE) begin
                        s_nxt.bad = 1'b1;
                    end else if (dec_src == SRC_IND &&
                                 dec_cls != CLS_CALL && dec_cls != CLS_JMP) begin
                        s_nxt.st = ST_PTR;
                    end else begin
                        s_nxt.st = ST_EXEC;
                    end
                end
            end
            ST_PTR: begin
                mem_req.addr = {3'b000, bank_sel, 2'b00, s_r.ins.opcode[0]};
                s_nxt.ptr    = mem_rdata;
                s_nxt.st     = ST_EXEC;
            end
            ST_EXEC: begin
                case (s_r.src)
                    SRC_REG: mem_req.addr = {3'b000, bank_sel,
                                             s_r.ins.opcode[2:0]};
                    SRC_IND: mem_req.addr = s_r.ptr;
                    default: mem_req.addr = dir_addr;
                endcase
                s_nxt.st   = ST_IDLE;
                s_nxt.done = 1'b1;
                s_nxt.pc   = s_r.pc + ((s_r.src == SRC_DIR ||
                             s_r.src == SRC_IMM) ? PC_STEP2 : PC_STEP1);
                case (s_r.cls)
                    CLS_ADD, CLS_ADD_WITH_CARRY: begin
                        s_nxt.acc = add_sum;
                        s_nxt.fl  = add_fl;
                    end
                    CLS_AND: begin
                        s_nxt.acc = s_r.acc & src_byte;
                    end
                    CLS_ANDD: begin
                        if (dir_is_port) begin
                            latch_we    = 1'b1;
                            latch_wdata = src_byte & s_r.acc;
                        end else begin
                            mem_req.we    = 1'b1;
                            mem_req.wdata = src_byte & s_r.acc;
                        end
                    end
                    CLS_JMP: begin
                        s_nxt.pc = page_tgt;
                    end
                    CLS_CALL: begin
                        s_nxt.sp      = s_r.sp + SP_STEP;
                        mem_req.addr  = s_r.sp + SP_STEP;
                        mem_req.we    = 1'b1;
                        mem_req.wdata = pc_inc[7:0];
                        s_nxt.pc      = pc_inc;
                        s_nxt.done    = 1'b0;
                        s_nxt.st      = ST_PUSH;
                    end
                    default: s_nxt.done = 1'b0;
                endcase
            end
            ST_PUSH: begin
                s_nxt.sp      = s_r.sp + SP_STEP;
                mem_req.addr  = s_r.sp + SP_STEP;
                mem_req.we    = 1'b1;
                mem_req.wdata = s_r.pc[15:8];
                s_nxt.pc      = {s_r.pc[15:11], s_r.ins.opcode[7:5],
                                 s_r.ins.operand};
                s_nxt.done    = 1'b1;
                s_nxt.st      = ST_IDLE;
            end
            default: s_nxt.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= STATE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign issue_ready     = (s_r.st == ST_IDLE);
    assign acc             = s_r.acc;
    assign flags           = s_r.fl;
    assign stack_pointer   = s_r.sp;
    assign program_counter = s_r.pc;
    assign done            = s_r.done;
    assign unsupported     = s_r.bad;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    logic [8:0] ref_sum9;
    assign ref_sum9 = {1'b0, s_r.acc} + {1'b0, src_byte} + {8'h00, add_cin};

    property p_call_sp;
        s_r.st == ST_EXEC && s_r.cls == CLS_CALL |->
            ##2 stack_pointer == $past(stack_pointer, 2) + SP_STEP + SP_STEP;
    endproperty
    a_call_sp: assert property (p_call_sp) else $error("call stack step");

    property p_call_tgt;
        s_r.st == ST_PUSH |=> program_counter[10:0] ==
            {$past(s_r.ins.opcode[7:5]), $past(s_r.ins.operand)};
    endproperty
    a_call_tgt: assert property (p_call_tgt) else $error("call target");

    property p_call_len;
        issue_valid && issue_ready && dec_cls == CLS_CALL |-> ##3 done;
    endproperty
    a_call_len: assert property (p_call_len) else $error("call length");

    property p_flags_keep;
        s_r.st == ST_EXEC && s_r.cls != CLS_ADD && s_r.cls != CLS_ADD_WITH_CARRY
            |=> $stable(flags) [*2];
    endproperty
    a_flags_keep: assert property (p_flags_keep) else $error("flags moved");

    property p_jmp_page;
        s_r.st == ST_EXEC && s_r.cls == CLS_JMP |=>
            program_counter[15:11] == $past(pc_inc[15:11]) && done;
    endproperty
    a_jmp_page: assert property (p_jmp_page) else $error("jump page");

    property p_add_cy;
        s_r.st == ST_EXEC && (s_r.cls == CLS_ADD || s_r.cls == CLS_ADD_WITH_CARRY)
            |=> {flags.cy, acc} == $past(ref_sum9);
    endproperty
    a_add_cy: assert property (p_add_cy) else $error("add sum or carry");

    property p_add_ov;
        s_r.st == ST_EXEC && s_r.cls == CLS_ADD |=> flags.ov ==
            ($past(s_r.acc[7]) == $past(src_byte[7]) &&
             acc[7] != $past(s_r.acc[7]));
    endproperty
    a_add_ov: assert property (p_add_ov) else $error("overflow flag");

    property p_and_acc;
        s_r.st == ST_EXEC && s_r.cls == CLS_AND
            |=> acc == ($past(s_r.acc) & $past(src_byte));
    endproperty
    a_and_acc: assert property (p_and_acc) else $error("and result");

    property p_and_port;
        s_r.st == ST_EXEC && s_r.cls == CLS_ANDD && dir_is_port
            |-> latch_we && !mem_req.we && latch_wdata == (latch_rdata & acc);
    endproperty
    a_and_port: assert property (p_and_port) else $error("port latch");

    c_call: cover property (s_r.st == ST_PUSH ##1 done);
    c_add_with_carry: cover property (s_r.st == ST_EXEC && s_r.cls == CLS_ADD_WITH_CARRY && add_fl.ov);
    c_ind:  cover property (s_r.st == ST_PTR ##1 s_r.cls == CLS_AND);
    c_port: cover property (latch_we);
endmodule
`default_nettype wire

// file: exec_pkg.sv
/*
 * Shared constants, encodings and carrier types for the call, jump,
 * add and logical-AND execution slice.
 * Assumes a single core clock and an asynchronous active-low reset.
 */
`default_nettype none
package exec_pkg;
    localparam int          DATA_W      = 8;
    localparam int          PC_W        = 16;
    localparam logic [7:0]  SP_RESET    = 8'h07;
    localparam logic [15:0] PC_RESET    = 16'h0000;
    localparam logic [15:0] PC_STEP2    = 16'h0002;
    localparam logic [15:0] PC_STEP1    = 16'h0001;
    localparam logic [7:0]  SP_STEP     = 8'h01;
    // Low five opcode bits of the page-addressed control transfers
    localparam logic [4:0]  CALL_LOW5   = 5'h11;
    localparam logic [4:0]  JMP_LOW5    = 5'h01;
    // Upper nibbles and fixed encodings of the byte operations
    localparam logic [3:0]  ADD_HI      = 4'h2;
    localparam logic [3:0]  ADD_WITH_CARRY_HI     = 4'h3;
    localparam logic [3:0]  AND_HI      = 4'h5;
    localparam logic [3:0]  LO_IMM      = 4'h4;
    localparam logic [3:0]  LO_DIR      = 4'h5;
    localparam logic [2:0]  LO_IND3     = 3'h3;
    localparam logic [7:0]  AND_DIR_ACC = 8'h52;
    // Output port latches sit at direct addresses 1xxx_0000
    localparam logic [3:0]  PORT_LOW    = 4'h0;

    typedef enum logic [2:0] {
        CLS_NONE = 3'b000,
        CLS_ADD  = 3'b001,
        CLS_ADD_WITH_CARRY = 3'b010,
        CLS_AND  = 3'b011,
        CLS_ANDD = 3'b100,
        CLS_CALL = 3'b101,
        CLS_JMP  = 3'b110
    } op_cls_t;

    typedef enum logic [1:0] {
        SRC_REG = 2'b00,
        SRC_DIR = 2'b01,
        SRC_IND = 2'b10,
        SRC_IMM = 2'b11
    } src_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PTR  = 2'b01,
        ST_EXEC = 2'b10,
        ST_PUSH = 2'b11
    } exec_st_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] operand;
    } instr_t;

    typedef struct packed {
        logic cy;
        logic ac;
        logic ov;
    } flags_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       we;
    } mem_req_t;
endpackage
`default_nettype wire

// file: byte_adder.sv
/*
 * Eight-bit adder with carry in, giving carry, auxiliary carry and
 * signed overflow. Purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
module byte_adder
    import exec_pkg::*;
(
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic       cin,
    output logic      [7:0] sum,
    output flags_t          flags
);
    logic [4:0] low4;
    logic [7:0] low7;
    logic [8:0] full;

    always_comb begin
        low4     = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        low7     = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
        full     = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        sum      = full[7:0];
        flags.cy = full[8];
        flags.ac = low4[4];
        flags.ov = low7[7] ^ full[8];
    end
endmodule
`default_nettype wire

// file: data_mem_model.sv
/* Far-side model: data RAM with asynchronous read and four port latches.
   Assumes the slice drives one-cycle write pulses on the core clock. */
`timescale 1ns/1ps
`default_nettype none
module data_mem_model
    import exec_pkg::*;
(
    input  wire logic       clk,
    input  wire mem_req_t   mem_req,
    output logic      [7:0] mem_rdata,
    input  wire logic [1:0] latch_sel,
    output logic      [7:0] latch_rdata,
    input  wire logic       latch_we,
    input  wire logic [7:0] latch_wdata
);
    logic [7:0] ram        [256];
    logic [7:0] port_latch [4];

    assign mem_rdata   = ram[mem_req.addr];
    assign latch_rdata = port_latch[latch_sel];

    always @(posedge clk) begin
        if (mem_req.we === 1'b1)
            ram[mem_req.addr] <= mem_req.wdata;
        if (latch_we === 1'b1)
            port_latch[latch_sel] <= latch_wdata;
    end
endmodule
`default_nettype wire

// file: tb_call_jump_add_and_exec.sv
/* Bench for exec_slice: byte adds and ANDs, page jumps, calls, refusals.
   Assumes data_mem_model answers the memory and port latch side. */
`timescale 1ns/1ps
`default_nettype none
module tb_call_jump_add_and_exec
    import exec_pkg::*;
;
    logic        clk, arst_n, issue_valid, issue_ready;
    logic        latch_we, done, unsupported;
    instr_t      issue;
    logic [1:0]  bank_sel, latch_sel;
    mem_req_t    mem_req;
    logic [7:0]  mem_rdata, latch_rdata, latch_wdata, acc, stack_pointer;
    flags_t      flags, flg_e;
    logic [15:0] program_counter, pc_e;
    logic [7:0]  acc_e, sp_e;
    int          n_errors, n_tests;
    logic [7:0]  dv [8] = '{8'hAA, 8'h0F, 8'h7E, 8'h81,
                            8'h3C, 8'hF9, 8'h44, 8'hC8};

    exec_slice DUT (.clk(clk), .arst_n(arst_n), .issue_valid(issue_valid),
        .issue_ready(issue_ready), .issue(issue), .bank_sel(bank_sel),
        .mem_req(mem_req), .mem_rdata(mem_rdata), .latch_sel(latch_sel),
        .latch_rdata(latch_rdata), .latch_we(latch_we),
        .latch_wdata(latch_wdata), .acc(acc), .flags(flags),
        .stack_pointer(stack_pointer), .program_counter(program_counter),
        .done(done), .unsupported(unsupported));

    data_mem_model mem (.clk(clk), .mem_req(mem_req),
        .mem_rdata(mem_rdata), .latch_sel(latch_sel),
        .latch_rdata(latch_rdata), .latch_we(latch_we),
        .latch_wdata(latch_wdata));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic end_sim;
        if (n_errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk_arch;
        chk("acc", {8'h00, acc_e}, {8'h00, acc});
        chk("flags", {13'h0, flg_e}, {13'h0, flags});
        chk("pc", pc_e, program_counter);
        chk("sp", {8'h00, sp_e}, {8'h00, stack_pointer});
    endtask

    // Carries out of bits 3, 6 and 7 worked out independently
    function automatic logic [10:0] ref_add(input logic [7:0] a, b,
                                            input logic c);
        logic [4:0] lo;
        logic [7:0] s6;
        logic [8:0] s;
        lo = 5'(a[3:0]) + 5'(b[3:0]) + 5'(c);
        s6 = 8'(a[6:0]) + 8'(b[6:0]) + 8'(c);
        s  = 9'(a) + 9'(b) + 9'(c);
        return {s[8], lo[4], s6[7] ^ s[8], s[7:0]};
    endfunction

    // Offer one instruction, count edges to completion, compare state
    task automatic run(input logic [7:0] opc, opd, input int lat,
                       input logic bad);
        int k;
        chk("ready", 16'h1, {15'h0, issue_ready});
        issue.opcode  = opc;
        issue.operand = opd;
        issue_valid   = 1'b1;
        @(posedge clk);
        #1 issue_valid = 1'b0;
        k = 1;
        while (done !== 1'b1 && unsupported !== 1'b1 && k < 8) begin
            @(posedge clk);
            #1 k++;
        end
        chk("latency", 16'(lat), 16'(k));
        chk("unsupported", {15'h0, bad}, {15'h0, unsupported});
        chk_arch;
    endtask

    task automatic byte_op(input logic [3:0] hi, input int m,
                           input logic [7:0] d);
        logic [7:0]  opc, opd;
        logic [10:0] r;
        opd      = d;
        bank_sel = 2'h2;
        case (m)
            0: begin
                mem.ram[8'h15] = d;
                opc = {hi, 4'hD};
            end
            1: begin
                mem.ram[8'h30] = d;
                opc = {hi, LO_DIR};
                opd = 8'h30;
            end
            2: begin
                mem.ram[8'h11] = 8'h41;
                mem.ram[8'h41] = d;
                opc = {hi, 4'h7};
            end
            default: opc = {hi, LO_IMM};
        endcase
        if (hi == AND_HI) begin
            acc_e = acc_e & d;
        end else begin
            r = ref_add(acc_e, d, (hi == ADD_WITH_CARRY_HI) & flg_e.cy);
            flg_e = r[10:8];
            acc_e = r[7:0];
        end
        pc_e = pc_e + (m[0] ? PC_STEP2 : PC_STEP1);
        run(opc, opd, (m == 2) ? 3 : 2, 1'b0);
    endtask

    task automatic s_add;
        byte_op(ADD_HI, 3, 8'hC3);
        byte_op(ADD_HI, 0, 8'hAA);
        for (int m = 0; m < 4; m++) begin
            byte_op(ADD_WITH_CARRY_HI, m, dv[m]);
            byte_op(ADD_HI, m, dv[m + 4]);
        end
    endtask

    task automatic s_and;
        for (int m = 0; m < 4; m++)
            byte_op(AND_HI, m, dv[7 - m] | 8'h81);
        byte_op(ADD_HI, 3, 8'h66);
        mem.ram[8'h32] = 8'h5F;
        mem.ram[8'h90] = 8'h00;
        mem.port_latch[1] = 8'hB7;
        pc_e = pc_e + PC_STEP2;
        run(AND_DIR_ACC, 8'h32, 2, 1'b0);
        chk("ram32", {8'h00, 8'h5F & acc_e}, {8'h00, mem.ram[8'h32]});
        pc_e = pc_e + PC_STEP2;
        run(AND_DIR_ACC, 8'h90, 2, 1'b0);
        chk("latch1", {8'h00, 8'hB7 & acc_e}, {8'h00, mem.port_latch[1]});
        chk("ram90", 16'h0000, {8'h00, mem.ram[8'h90]});
    endtask

    task automatic do_call(input logic [7:0] opc, opd,
                           input logic [15:0] tgt);
        logic [15:0] ret;
        ret  = pc_e + PC_STEP2;
        sp_e = sp_e + 8'h02;
        pc_e = tgt;
        run(opc, opd, 3, 1'b0);
        chk("push_lo", {8'h00, ret[7:0]}, {8'h00, mem.ram[sp_e - 8'h01]});
        chk("push_hi", {8'h00, ret[15:8]}, {8'h00, mem.ram[sp_e]});
    endtask

    task automatic s_jump_call;
        pc_e = 16'h07FE;
        run(8'hE1, 8'hFE, 2, 1'b0);
        pc_e = 16'h0934;
        run(8'h21, 8'h34, 2, 1'b0);
        do_call(8'hB1, 8'h45, 16'h0D45);
        do_call(8'h11, 8'h00, 16'h0800);
    endtask

    task automatic s_bad;
        run(8'h53, 8'h30, 1, 1'b1);
        run(8'h50, 8'h30, 1, 1'b1);
        run(8'h00, 8'h00, 1, 1'b1);
    endtask

    initial begin
        arst_n      = 1'b0;
        issue_valid = 1'b0;
        issue       = '0;
        bank_sel    = 2'h0;
        n_errors    = 0;
        n_tests     = 0;
        acc_e       = 8'h00;
        flg_e       = '0;
        pc_e        = PC_RESET;
        sp_e        = SP_RESET;
        repeat (6) @(posedge clk);
        #1 arst_n = 1'b1;
        chk_arch;
        s_add;
        s_and;
        s_jump_call;
        s_bad;
        end_sim;
    end

    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        end_sim;
    end
endmodule
`default_nettype wire
